// ===== dmi_ctrl.sv
// ddr3 reset, initialisation and mode register set sequencer (controller side)
// Function
// RULE1 - device keeps its termination off in reset and until cke registered high
// RULE2 - odt held static low from before cke high until dllk and zqinit expire
// RULE3 - wait txpr, max of txs and 5 clocks, after cke high before first mrs
// RULE4 - init loads mr2, mr3, mr1 dll on, then mr0 with dll reset
// RULE5 - bank address selects mr0..mr3 as 000, 001, 010, 011
// RULE6 - a0 low in mr1 enables dll; a8 high in mr0 resets dll
// RULE7 - after loads issue zq long calibration, then wait dllk and zqinit
// RULE8 - only nop or deselect between init mrs commands and zq calibration
// RULE9 - stable power reset: reset at least 100 ns, cke low 10 ns before release
// RULE10 - all four mode registers written before relying on them
// RULE11 - every mrs presents the full register value on all address bits
// RULE12 - mrs and dll reset leave the array contents unchanged
// RULE13 - consecutive mrs commands spaced by at least tmrd
// RULE14 - after mrs wait tmod before any non mrs, nop or deselect command
// RULE15 - runtime mrs only when idle: banks precharged, bursts done, cke high
// RULE16 - with rtt_nom on, odt low before mrs and until tmod expires
// RULE17 - mrs is cs, ras, cas, we all low; mr0 also needs bank bits low
// RULE18 - mr0 load drives ba2, a13 and a14 to zero
// RULE19 - mr0 a3 selects sequential or interleaved burst order
// RULE20 - mr0 a0-a1 choose fixed bc4, fixed bl8, or on the fly by a12
// RULE21 - bl8 read order: sequential wraps by nibble, interleaved is i xor c
// RULE22 - bc4 read gives first four words then tristates the rest
// RULE23 - writes ignore low column bits; bc4 stores half chosen by a2
// RULE24 - t beats mean data and strobe drivers are high impedance
// RULE25 - wait 500 us after reset release before raising cke
// RULE26 - stable clock at least max of 10 ns and 5 clocks with nop before cke
// RULE27 - cke stays high from first registration until init completes
// RULE28 - symbolic timings are configurable clock cycle counts
`timescale 1ns/100ps
module dmi_ctrl
    import dmi_pkg::*;
#(
    parameter int RST_HOLD_CYC = dmi_pkg::DMI_RST_HOLD_CYC,
    parameter int CKE_WAIT_CYC = dmi_pkg::DMI_CKE_WAIT_CYC,
    parameter int T_XS = 10, // RULE28
    parameter int T_MRD = 4,
    parameter int T_MOD = 12,
    parameter int T_DLLK = 512,
    parameter int T_ZQINIT = 512,
    parameter logic [14:0] MR0_INIT = 15'h0000,
    parameter logic [14:0] MR1_INIT = 15'h0000,
    parameter logic [14:0] MR2_INIT = 15'h0000,
    parameter logic [14:0] MR3_INIT = 15'h0000
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // user side
    input wire logic usr_start,
    input wire logic usr_mrs_req,
    input wire logic [1:0] usr_mrs_sel,
    input wire logic [dmi_pkg::DMI_ADDR_W-1:0] usr_mrs_val,
    input wire logic usr_idle,
    input wire logic usr_odt,
    output logic usr_mrs_ack,
    output logic init_done,
    output logic [dmi_pkg::DMI_ADDR_W-1:0] mr0_shadow,
    // memory pins
    output logic ddr_reset_n,
    output logic ddr_cke,
    output logic ddr_odt,
    output logic ddr_cs_n,
    output logic ddr_ras_n,
    output logic ddr_cas_n,
    output logic ddr_we_n,
    output logic [dmi_pkg::DMI_BA_W-1:0] ddr_ba,
    output logic [dmi_pkg::DMI_ADDR_W-1:0] ddr_addr
);
    import dmi_pkg::*;

    localparam int CW = 24;
    localparam int XPR_CYC = (T_XS > DMI_XPR_TCK) ? T_XS : DMI_XPR_TCK;
    localparam int DLLZQ_CYC = (T_DLLK > T_ZQINIT) ? T_DLLK : T_ZQINIT;
    localparam int RST_CYC = (RST_HOLD_CYC > DMI_RST_STABLE_CYC) ? RST_HOLD_CYC : DMI_RST_STABLE_CYC;

    ////////////////////////////////////////////////////////////////////////
    dmi_state_t state_reg, state_next;
    logic [1:0] mr_idx_reg, mr_idx_next;
    logic [3:0] cmd_reg, cmd_next;
    logic [2:0] ba_reg, ba_next;
    logic [14:0] addr_reg, addr_next;
    logic [14:0] mr0_reg, mr0_next;
    logic reset_n_reg, reset_n_next;
    logic cke_reg, cke_next;
    logic odt_reg, odt_next;
    logic ack_reg, ack_next;
    logic done_reg, done_next;
    logic ld;
    logic [CW-1:0] ld_val;
    logic tmr_done;
    logic first_reg;

    dmi_wait_cnt #(.W(CW)) u_wait (
        .mclk(mclk),
        .rst(rst),
        .load(ld),
        .count(ld_val),
        .done(tmr_done)
    );

    // init load order mr2, mr3, mr1, mr0 with its bank and value
    logic [2:0] init_ba;
    logic [14:0] init_val;
    assign init_ba = (mr_idx_reg == 2'h0) ? DMI_BA_MR2 : (mr_idx_reg == 2'h1) ? DMI_BA_MR3 : // RULE4 RULE5
                     (mr_idx_reg == 2'h2) ? DMI_BA_MR1 : DMI_BA_MR0;
    // mr1 forces dll on, mr0 forces dll reset and clears reserved bits
    logic [14:0] mr1_fix, mr0_fix, usr_fix;
    assign mr1_fix = MR1_INIT & ~(15'h0001 << DMI_MR1_DLL_DIS_BIT); // RULE6
    assign mr0_fix = (MR0_INIT & 15'h1fff) | (15'h0001 << DMI_MR0_DLL_RST_BIT); // RULE6 RULE18 RULE19 RULE20
    assign usr_fix = (usr_mrs_sel == 2'h0) ? (usr_mrs_val & 15'h1fff) : usr_mrs_val; // RULE18
    assign init_val = (mr_idx_reg == 2'h0) ? MR2_INIT : (mr_idx_reg == 2'h1) ? MR3_INIT : // RULE11
                      (mr_idx_reg == 2'h2) ? mr1_fix : mr0_fix;
    logic usr_go;
    assign usr_go = usr_mrs_req && usr_idle && !ack_reg; // RULE15

    always_comb begin
        state_next = state_reg;
        mr_idx_next = mr_idx_reg;
        cmd_next = DMI_CMD_NOP; // RULE8
        ba_next = 3'h0;
        addr_next = 15'h0000;
        mr0_next = mr0_reg;
        reset_n_next = reset_n_reg;
        cke_next = cke_reg;
        odt_next = 1'b0;
        ack_next = 1'b0;
        done_next = done_reg;
        ld = 1'b0;
        ld_val = '0;
        unique case (state_reg)
            DMI_S_RST: begin
                reset_n_next = 1'b0;
                cke_next = 1'b0; // RULE9
                done_next = 1'b0;
                if (first_reg) begin
                    ld = 1'b1; // RULE9
                    ld_val = CW'(RST_CYC);
                end else if (tmr_done && usr_start) begin
                    reset_n_next = 1'b1; // RULE9
                    ld = 1'b1;
                    ld_val = CW'(CKE_WAIT_CYC);
                    state_next = DMI_S_CKEWAIT;
                end
            end
            DMI_S_CKEWAIT: begin
                if (tmr_done) begin // RULE25
                    ld = 1'b1;
                    ld_val = CW'(DMI_CLK_STAB_CYC);
                    state_next = DMI_S_CLKSTAB;
                end
            end
            DMI_S_CLKSTAB: begin
                if (tmr_done) begin // RULE26
                    cke_next = 1'b1;
                    ld = 1'b1;
                    ld_val = CW'(XPR_CYC);
                    state_next = DMI_S_XPR;
                end
            end
            DMI_S_XPR: begin
                if (tmr_done) begin // RULE3
                    mr_idx_next = 2'h0;
                    state_next = DMI_S_MRS;
                end
            end
            DMI_S_MRS: begin
                cmd_next = DMI_CMD_MRS; // RULE17
                ba_next = init_ba;
                addr_next = init_val;
                if (mr_idx_reg == 2'h3) begin
                    mr0_next = init_val;
                end
                ld = 1'b1;
                ld_val = (mr_idx_reg == 2'h3) ? CW'(T_MOD) : CW'(T_MRD); // RULE13 RULE14
                state_next = DMI_S_MRGAP;
            end
            DMI_S_MRGAP: begin
                if (tmr_done) begin
                    mr_idx_next = mr_idx_reg + 2'h1;
                    state_next = (mr_idx_reg == 2'h3) ? DMI_S_ZQ : DMI_S_MRS; // RULE10
                end
            end
            DMI_S_ZQ: begin
                cmd_next = DMI_CMD_ZQCL; // RULE7
                addr_next = DMI_ZQCL_ADDR;
                ld = 1'b1;
                ld_val = CW'(DLLZQ_CYC);
                state_next = DMI_S_DLLZQ;
            end
            DMI_S_DLLZQ: begin
                if (tmr_done) begin // RULE7 RULE27
                    done_next = 1'b1;
                    state_next = DMI_S_READY;
                end
            end
            DMI_S_READY: begin
                odt_next = usr_odt;
                if (usr_go) begin
                    odt_next = 1'b0; // RULE16
                    state_next = DMI_S_USRMRS;
                end
            end
            DMI_S_USRMRS: begin
                cmd_next = DMI_CMD_MRS; // RULE17
                ba_next = {1'b0, usr_mrs_sel}; // RULE5
                addr_next = usr_fix; // RULE11
                if (usr_mrs_sel == 2'h0) begin
                    mr0_next = usr_fix;
                end
                ld = 1'b1;
                ld_val = CW'(T_MOD);
                state_next = DMI_S_USRMOD;
            end
            DMI_S_USRMOD: begin
                if (tmr_done) begin // RULE14 RULE16
                    ack_next = 1'b1;
                    state_next = DMI_S_READY;
                end
            end
            default: begin
                state_next = DMI_S_RST;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= DMI_S_RST;
            mr_idx_reg <= 2'h0;
            cmd_reg <= DMI_CMD_NOP;
            ba_reg <= 3'h0;
            addr_reg <= 15'h0000;
            mr0_reg <= 15'h0000;
            reset_n_reg <= 1'b0;
            cke_reg <= 1'b0;
            odt_reg <= 1'b0;
            ack_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            mr_idx_reg <= mr_idx_next;
            cmd_reg <= cmd_next;
            ba_reg <= ba_next;
            addr_reg <= addr_next;
            mr0_reg <= mr0_next;
            reset_n_reg <= reset_n_next;
            cke_reg <= cke_next;
            odt_reg <= odt_next;
            ack_reg <= ack_next;
            done_reg <= done_next;
        end
    end

    // reset hold starts at reset: counter loads on the first cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            first_reg <= 1'b1;
        end else begin
            first_reg <= 1'b0;
        end
    end
    assign ddr_reset_n = reset_n_reg;
    assign ddr_cke = cke_reg;
    assign ddr_odt = odt_reg; // RULE2
    assign ddr_cs_n = cmd_reg[3];
    assign ddr_ras_n = cmd_reg[2];
    assign ddr_cas_n = cmd_reg[1];
    assign ddr_we_n = cmd_reg[0];
    assign ddr_ba = ba_reg;
    assign ddr_addr = addr_reg;
    assign usr_mrs_ack = ack_reg;
    assign init_done = done_reg;
    assign mr0_shadow = mr0_reg;

    ////////////////////////////////////////////////////////////////////////
    // rst hold counter: separate check of reset length
    logic [CW-1:0] rlow_cnt;
    always_ff @(posedge mclk) begin
        if (rst || reset_n_reg) begin
            rlow_cnt <= '0;
        end else if (rlow_cnt != '1) begin
            rlow_cnt <= rlow_cnt + CW'(1);
        end
    end

    a_rst_len: assert property (@(posedge mclk) disable iff (rst) // RULE9
        $rose(reset_n_reg) |-> rlow_cnt >= CW'(DMI_RST_STABLE_CYC - 1))
        else $error("reset released too early");
    a_cke_low_rel: assert property (@(posedge mclk) disable iff (rst) // RULE9
        $rose(reset_n_reg) |-> !cke_reg ##1 !cke_reg)
        else $error("cke not low around reset release");
    a_cke_stay: assert property (@(posedge mclk) disable iff (rst) // RULE27
        cke_reg && !done_reg && state_reg != DMI_S_RST |=> cke_reg)
        else $error("cke dropped during init");
    a_odt_init: assert property (@(posedge mclk) disable iff (rst) // RULE2
        !done_reg |-> !odt_reg)
        else $error("odt moved during init");
    a_mrs_space: assert property (@(posedge mclk) disable iff (rst) // RULE13
        cmd_reg == DMI_CMD_MRS |=> cmd_reg != DMI_CMD_MRS [*3])
        else $error("mrs spacing too short");
    a_mod_wait: assert property (@(posedge mclk) disable iff (rst) // RULE14
        cmd_reg == DMI_CMD_MRS |=> (cmd_reg == DMI_CMD_NOP || cmd_reg == DMI_CMD_MRS) [*8])
        else $error("command inside tmod");
    a_mr0_resv: assert property (@(posedge mclk) disable iff (rst) // RULE18
        cmd_reg == DMI_CMD_MRS && ba_reg[1:0] == 2'h0 |-> ba_reg[2] == 1'b0 && addr_reg[14:13] == 2'h0)
        else $error("mr0 reserved bits set");
    a_dll_bits: assert property (@(posedge mclk) disable iff (rst) // RULE6
        cmd_reg == DMI_CMD_MRS && !done_reg && ba_reg == DMI_BA_MR1 |-> !addr_reg[DMI_MR1_DLL_DIS_BIT])
        else $error("dll not enabled in mr1");
    a_zq_after: assert property (@(posedge mclk) disable iff (rst) // RULE7
        cmd_reg == DMI_CMD_ZQCL |-> ##1 !done_reg [*8])
        else $error("ready too soon after zq");
    a_xpr_wait: assert property (@(posedge mclk) disable iff (rst) // RULE3
        $rose(cke_reg) |-> (cmd_reg != DMI_CMD_MRS) [*5])
        else $error("mrs inside txpr");
    c_init: cover property (@(posedge mclk) $rose(done_reg));
    c_usr_mrs: cover property (@(posedge mclk) ack_reg);
    c_zq: cover property (@(posedge mclk) cmd_reg == DMI_CMD_ZQCL);
endmodule // dmi_ctrl

// ===== dmi_dev_model.sv
// behavioural ddr3 device at the far side: mode registers and a log of pin timing
`timescale 1ns/100ps
module dmi_dev_model #(
    parameter int T_MOD = 12,
    parameter int T_INIT = 20
) (
    // clock
    input wire logic mclk,
    // memory pins
    input wire logic reset_n,
    input wire logic cke,
    input wire logic odt,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [dmi_pkg::DMI_BA_W-1:0] ba,
    input wire logic [dmi_pkg::DMI_ADDR_W-1:0] addr
);
    import dmi_pkg::*;
    logic [DMI_ADDR_W-1:0] mr [4];
    logic [3:0] cmd;
    logic cke_seen = 0, zq_seen = 0, zq_pend = 0;
    logic rtt_on, dll_on, burst_il;
    logic [1:0] bl_mode;
    logic [63:0] array_word = 64'h0123456789abcdef;
    int cyc = 0, t_rstn_fall = 0, t_rstn = 0, t_cke = 0, t_mrs = 0, t_zq = 0;
    int n_mrs = 0, n_dllrst = 0, odt_bad = 0, cmd_bad = 0, cke_drop = 0, gap_min = 1000;
    int t_log[$];
    logic [2:0] ba_log[$];
    // read beat word index for start column c; 4'h8 marks an idle beat
    function automatic logic [3:0] rd_beat(logic il, logic bc4, logic [2:0] c, logic [2:0] i);
        if (bc4 && i[2]) return 4'h8;
        if (il) return {1'b0, c ^ i};
        return {1'b0, c[2] ^ i[2], c[1:0] + i[1:0]};
    endfunction
    // write beat word index: low column bits ignored, bc4 half chosen by a2
    function automatic logic [2:0] wr_beat(logic bc4, logic [2:0] c, logic [2:0] i);
        return (bc4 && c[2]) ? 3'h4 + i : i;
    endfunction
    assign cmd = {cs_n, ras_n, cas_n, we_n};
    assign rtt_on = cke_seen && odt;
    assign dll_on = !mr[1][DMI_MR1_DLL_DIS_BIT];
    assign burst_il = mr[0][DMI_MR0_BT_BIT];
    assign bl_mode = mr[0][1:0];
    ////////////////////////////////////////////////////////////////
    always @(posedge mclk) begin
        cyc++;
        if (!reset_n) begin
            cke_seen = 0;
            zq_seen = 0;
            zq_pend = 0;
            n_dllrst = 0;
            ba_log.delete();
            t_log.delete();
            foreach (mr[i]) mr[i] = 'x;
            if (t_rstn >= t_rstn_fall) t_rstn_fall = cyc;
        end else if (t_rstn < t_rstn_fall) t_rstn = cyc;
        if (reset_n && cke && !cke_seen) begin
            cke_seen = 1;
            t_cke = cyc;
        end
        if (reset_n && cke_seen && !cke) cke_drop++;
        if (odt && (!zq_seen || cyc - t_zq < T_INIT || cyc - t_mrs < T_MOD)) odt_bad++;
        if (reset_n && cmd == DMI_CMD_MRS) begin
            if (n_mrs > 0 && cyc - t_mrs < gap_min) gap_min = cyc - t_mrs;
            mr[ba[1:0]] = addr;
            if (ba == DMI_BA_MR0 && addr[DMI_MR0_DLL_RST_BIT]) n_dllrst++;
            if (!cke_seen) cmd_bad++;
            ba_log.push_back(ba);
            t_log.push_back(cyc);
            t_mrs = cyc;
            n_mrs++;
            zq_pend = !zq_seen;
        end else if (reset_n && cmd == DMI_CMD_ZQCL) begin
            zq_pend = 0;
            zq_seen = 1;
            t_zq = cyc;
        end else if (zq_pend && cmd != DMI_CMD_NOP && !cmd[3]) cmd_bad++;
    end
endmodule // dmi_dev_model

// ===== dmi_pkg.sv
// shared constants for the ddr3 init and mode register sequencer
package dmi_pkg;
    localparam int DMI_CLK_NS = 40;
    localparam int DMI_ADDR_W = 15;
    localparam int DMI_BA_W = 3;
    // times in their own units
    localparam int DMI_RST_HOLD_NS = 200000;
    localparam int DMI_RST_STABLE_NS = 100;
    localparam int DMI_CKE_LOW_NS = 10;
    localparam int DMI_CKE_WAIT_US = 500;
    localparam int DMI_CLK_STAB_NS = 10;
    localparam int DMI_CLK_STAB_TCK = 5;
    localparam int DMI_XPR_TCK = 5;
    // derived cycle counts, least times round up
    localparam int DMI_RST_HOLD_CYC = (DMI_RST_HOLD_NS + DMI_CLK_NS - 1) / DMI_CLK_NS;
    localparam int DMI_RST_STABLE_CYC = (DMI_RST_STABLE_NS + DMI_CLK_NS - 1) / DMI_CLK_NS;
    localparam int DMI_CKE_WAIT_CYC = (DMI_CKE_WAIT_US * 1000 + DMI_CLK_NS - 1) / DMI_CLK_NS;
    localparam int DMI_CLK_STAB_CYC = ((DMI_CLK_STAB_NS + DMI_CLK_NS - 1) / DMI_CLK_NS > DMI_CLK_STAB_TCK) ?
        (DMI_CLK_STAB_NS + DMI_CLK_NS - 1) / DMI_CLK_NS : DMI_CLK_STAB_TCK;
    // bank selects of the four mode registers
    localparam logic [2:0] DMI_BA_MR0 = 3'h0;
    localparam logic [2:0] DMI_BA_MR1 = 3'h1;
    localparam logic [2:0] DMI_BA_MR2 = 3'h2;
    localparam logic [2:0] DMI_BA_MR3 = 3'h3;
    localparam int DMI_MR1_DLL_DIS_BIT = 0;
    localparam int DMI_MR0_DLL_RST_BIT = 8;
    localparam int DMI_MR0_BT_BIT = 3;
    localparam int DMI_BC_OTF_BIT = 12;
    localparam logic [1:0] DMI_BL_FIXED8 = 2'h0;
    localparam logic [1:0] DMI_BL_OTF = 2'h1;
    localparam logic [1:0] DMI_BL_FIXED4 = 2'h2;
    // command encodings {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] DMI_CMD_NOP = 4'h7;
    localparam logic [3:0] DMI_CMD_DES = 4'h8;
    localparam logic [3:0] DMI_CMD_MRS = 4'h0;
    localparam logic [3:0] DMI_CMD_ZQCL = 4'h6;
    localparam logic [DMI_ADDR_W-1:0] DMI_ZQCL_ADDR = 15'h0400;
    typedef enum logic [3:0] {
        DMI_S_RST, DMI_S_CKEWAIT, DMI_S_CLKSTAB, DMI_S_XPR, DMI_S_MRS, DMI_S_MRGAP,
        DMI_S_ZQ, DMI_S_DLLZQ, DMI_S_READY, DMI_S_USRMRS, DMI_S_USRMOD
    } dmi_state_t;
endpackage

// ===== dmi_wait_cnt.sv
// down counter that times one wait of the sequencer
`timescale 1ns/100ps
module dmi_wait_cnt #(
    parameter int W = 24
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // load and status
    input wire logic load,
    input wire logic [W-1:0] count,
    output logic done
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    assign cnt_next = load ? count : ((cnt_reg != '0) ? cnt_reg - W'(1) : cnt_reg);
    // status depends on the register only, so the caller may load on done without a loop
    assign done = (cnt_reg == '0);
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule // dmi_wait_cnt

// ===== testbench.sv
// self-checking bench for the ddr3 init and mode register sequencer
`timescale 1ns/100ps
module testbench;
    import dmi_pkg::*;
    localparam int RSTH = 8, CKW = 20, TXS = 10, TMRD = 4, TMOD = 12, TDLLK = 16, TZQ = 20;
    logic mclk = 0, rst = 1, usr_start = 0, usr_mrs_req = 0, usr_idle = 0, usr_odt = 0;
    logic [1:0] usr_mrs_sel = 0;
    logic [DMI_ADDR_W-1:0] usr_mrs_val = 0, mr0_shadow, ddr_addr;
    logic usr_mrs_ack, init_done, ddr_reset_n, ddr_cke, ddr_odt, ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n;
    logic [DMI_BA_W-1:0] ddr_ba;
    int bad_count = 0, n_tests = 0;
    always #20 mclk = ~mclk;
    dmi_ctrl #(.RST_HOLD_CYC(RSTH), .CKE_WAIT_CYC(CKW), .T_XS(TXS), .T_MRD(TMRD), .T_MOD(TMOD),
        .T_DLLK(TDLLK), .T_ZQINIT(TZQ),
        .MR0_INIT(15'h6c31), .MR1_INIT(15'h0045), .MR2_INIT(15'h0018), .MR3_INIT(15'h0004)) dut (
        .mclk(mclk), .rst(rst), .usr_start(usr_start), .usr_mrs_req(usr_mrs_req), .usr_mrs_sel(usr_mrs_sel),
        .usr_mrs_val(usr_mrs_val), .usr_idle(usr_idle), .usr_odt(usr_odt), .usr_mrs_ack(usr_mrs_ack),
        .init_done(init_done), .mr0_shadow(mr0_shadow), .ddr_reset_n(ddr_reset_n), .ddr_cke(ddr_cke),
        .ddr_odt(ddr_odt), .ddr_cs_n(ddr_cs_n), .ddr_ras_n(ddr_ras_n), .ddr_cas_n(ddr_cas_n),
        .ddr_we_n(ddr_we_n), .ddr_ba(ddr_ba), .ddr_addr(ddr_addr));
    dmi_dev_model #(.T_MOD(TMOD), .T_INIT(TZQ)) model (.mclk(mclk), .reset_n(ddr_reset_n), .cke(ddr_cke),
        .odt(ddr_odt), .cs_n(ddr_cs_n), .ras_n(ddr_ras_n), .cas_n(ddr_cas_n), .we_n(ddr_we_n), .ba(ddr_ba),
        .addr(ddr_addr));
    ////////////////////////////////////////////////////////////////
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task stop_test;
        if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////
    // power-up or stable-power init, pins held in reset until start
    task run_init;
        int w;
        // start and odt wanted from release: the hold and the init must still mask them
        usr_start = 1;
        usr_odt = 1;
        step(6);
        check("rstn_held", ddr_reset_n, 1'b0);
        check("cke_low", ddr_cke, 1'b0);
        w = 0;
        while (init_done !== 1'b1 && w < 400) begin
            step(1);
            w++;
        end
        usr_start = 0;
        check("init_done", init_done, 1'b1);
        check("rst_len", model.t_rstn - model.t_rstn_fall >= RSTH, 1'b1);
        check("cke_wait", model.t_cke - model.t_rstn >= CKW, 1'b1);
        check("mrs_count", model.ba_log.size(), 4);
        check("order", {model.ba_log[0], model.ba_log[1], model.ba_log[2], model.ba_log[3]}, 12'h4c8);
        check("txpr", model.t_log[0] - model.t_cke >= TXS, 1'b1);
        check("tmrd", model.gap_min >= TMRD, 1'b1);
        check("zq_tmod", model.t_zq - model.t_log[3] >= TMOD, 1'b1);
        check("zq_wait", model.cyc - model.t_zq >= TZQ, 1'b1);
        check("mr0", model.mr[0], 15'h0d31);
        check("mr1", model.mr[1], 15'h0044);
        check("mr2", model.mr[2], 15'h0018);
        check("mr3", model.mr[3], 15'h0004);
        check("dll", {model.dll_on, model.n_dllrst == 1}, 2'h3);
        check("bl_mode", model.bl_mode, DMI_BL_OTF);
        check("burst_seq", model.burst_il, 1'b0);
        check("shadow", mr0_shadow, 15'h0d31);
        check("cmd_between", model.cmd_bad, 0);
        check("cke_steady", model.cke_drop, 0);
        check("odt_init", model.odt_bad, 0);
    endtask
    // burst order of the far side against the read and write tables
    task burst_order;
        logic [31:0] sq, il, bc, w8, w4;
        for (int i = 0; i < 8; i++) begin
            sq = {sq[27:0], model.rd_beat(1'b0, 1'b0, 3'h5, 3'(i))};
            il = {il[27:0], model.rd_beat(1'b1, 1'b0, 3'h1, 3'(i))};
            bc = {bc[27:0], model.rd_beat(1'b0, 1'b1, 3'h3, 3'(i))};
            w8 = {w8[27:0], 1'b0, model.wr_beat(1'b0, 3'h7, 3'(i))};
            w4 = {w4[27:0], 1'b0, model.wr_beat(1'b1, 3'h4, 3'(i))};
        end
        check("rd_seq", sq, 32'h56741230);
        check("rd_il", il, 32'h10325476);
        check("rd_bc4", bc, 32'h30128888);
        check("wr_bl8", w8, 32'h01234567);
        check("wr_bc4", w4[31:16], 16'h4567);
    endtask
    // runtime load: refused while busy, then taken once idle
    task rt_mrs(input logic [1:0] sel, input logic [14:0] val, input logic [14:0] exp);
        int w, n0;
        n0 = model.n_mrs;
        usr_mrs_sel = sel;
        usr_mrs_val = val;
        usr_mrs_req = 1;
        usr_idle = 0;
        usr_odt = 1;
        step(30);
        check("idle_refuse", model.n_mrs, n0);
        usr_idle = 1;
        w = 0;
        while (usr_mrs_ack !== 1'b1 && w < 100) begin
            step(1);
            w++;
        end
        check("rt_ack", usr_mrs_ack, 1'b1);
        usr_mrs_req = 0;
        usr_idle = 0;
        check("rt_tmod", model.cyc - model.t_mrs >= TMOD, 1'b1);
        check("rt_count", model.n_mrs, n0 + 1);
        check("rt_reg", model.mr[sel], exp);
        step(3);
        check("odt_back", ddr_odt, 1'b1);
        check("odt_rules", model.odt_bad, 0);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        step(4);
        rst = 0;
        run_init;
        rt_mrs(2'h0, 15'h7fff, 15'h1fff);
        check("rt_shadow", mr0_shadow, 15'h1fff);
        check("rt_burst", {model.burst_il, model.bl_mode}, 3'h7);
        rt_mrs(2'h2, 15'h0208, 15'h0208);
        usr_odt = 0;
        rst = 1;
        step(4);
        rst = 0;
        run_init;
        burst_order;
        stop_test;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        bad_count++;
        stop_test;
    end
endmodule // testbench
